// ==== rtl/ursm_pkg.sv ====
// shared constants and types for the serial channel register set
package ursm_pkg;
  // register offsets on the host port
  localparam logic [3:0] OFS_DATA = 4'h0;  // rx/tx data, divisor low
  localparam logic [3:0] OFS_IEN = 4'h1;   // irq enable, divisor high
  localparam logic [3:0] OFS_IID = 4'h2;   // irq ident / fifo control
  localparam logic [3:0] OFS_LFMT = 4'h3;  // line format
  localparam logic [3:0] OFS_MCTL = 4'h4;  // modem control
  localparam logic [3:0] OFS_LST = 4'h5;   // line state
  localparam logic [3:0] OFS_MST = 4'h6;   // modem state
  localparam logic [3:0] OFS_SPARE = 4'h7; // spare byte
  localparam logic [3:0] OFS_EVT_STAT = 4'h8; // sticky event status, ro
  localparam logic [3:0] OFS_EVT_EN = 4'h9;   // event enable, rw
  localparam logic [3:0] OFS_EVT_CLR = 4'hA;  // event clear, wo
  // field positions in the line format byte
  localparam int LF_STOP = 2;    // stop_bit_count
  localparam int LF_PAR = 3;     // parity_on
  localparam int LF_EVEN = 4;    // even_parity_select
  localparam int LF_STICK = 5;   // stick parity
  localparam int LF_BREAK = 6;   // force break
  localparam int LF_DIV = 7;     // divisor_access_select
  // modem control fields
  localparam int MC_LOOP = 4;
  // event bit positions
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_ERR = 2;
  localparam int EV_MODEM = 3;
  // values after reset
  localparam logic [7:0] LST_RESET = 8'h60;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  // identification codes
  localparam logic [7:0] IID_NONE = 8'h01;
  localparam logic [7:0] IID_LINE = 8'h06;
  localparam logic [7:0] IID_RX = 8'h04;
  localparam logic [7:0] IID_TX = 8'h02;
  localparam logic [7:0] IID_MODEM = 8'h00;
  // oversampling: sixteen ticks per bit, mid-bit at seven
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [3:0] SUB_MID = 4'h7;
  // host port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ursm_bus_req_s;
endpackage : ursm_pkg

// ==== rtl/ursm_channel.sv ====
// register set and serial engine of one asynchronous serial channel
// Notes on behaviour
// - line format bit 7 remaps offsets to divisor
// - offset 0 reads rx char, writes tx
// - bit 0 shifted first, sampled first
// - four irq enables, bits 7..4 zero
// - fifo status bits read zero, no fifo
// - dma select bit ignored entirely
// - aux outputs are storage only, no pin
// - xt mode: tx empty follows shift register
// - xt mode: spare byte unavailable
// - line state resets to bits 5,6 only
// - line status irq beats rx data irq
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
module ursm_channel (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // host register port
  input wire ursm_pkg::ursm_bus_req_s req_i,
  output logic [7:0] rdata_o,
  // mode strap, held static
  input wire logic xt_mode_i,
  // serial line
  input wire logic rxd_i,
  output logic txd_o,
  // modem lines, active high inside the chip
  input wire logic cts_i,
  input wire logic dsr_i,
  input wire logic ri_i,
  input wire logic dcd_i,
  output logic dtr_o,
  output logic rts_o,
  // interrupt
  output logic irq_o
);
  import ursm_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PAR = 3'b011,
    ST_STOP = 3'b100
  } ursm_state_e;

  logic [7:0] ien;         // irq_enable_mask, low nibble only used
  logic [7:0] lfmt;        // line_format
  logic [7:0] mctl;        // modem_ctrl
  logic [7:0] spare;       // spare_byte
  logic [15:0] divisor;    // baud divisor
  logic [15:0] div_cnt;    // 16x tick counter
  logic tick;              // one 16x oversample tick
  logic [7:0] thr_data;    // tx_holding_write contents
  logic thr_full;          // holding register occupied
  logic tx_load;           // holding moves into shift register
  logic tx_holding_empty_irq;          // tx empty irq latch, cleared by ident read
  ursm_state_e tx_state;
  logic [3:0] tx_sub;
  logic [2:0] tx_idx;
  logic tx_stop2;          // second stop bit pending
  logic [7:0] tx_sr;       // bits being sent, masked to word length
  ursm_state_e rx_state;
  logic [3:0] rx_sub;
  logic [2:0] rx_idx;
  logic [7:0] rx_sr;
  logic rx_pbit;           // captured parity bit
  logic [7:0] rx_data;     // rx_buffer_read contents
  logic rx_done;           // one char delivered this cycle
  logic rx_pe, rx_fe, rx_bi;
  logic dr, oe, pe, fe, bi; // line state flags
  logic [3:0] mdelta;      // modem deltas
  logic [3:0] mprev;       // previous modem line levels
  logic [3:0] mnow;
  logic [3:0] evt_stat, evt_en;
  logic [2:0] wlast;       // index of last data bit
  logic rx_in;
  logic tx_holding_empty, tx_all_empty;
  logic [7:0] lst_v, iid_v, rd_v;
  logic dsel;
  logic wr_any, rd_any;

  assign dsel = lfmt[LF_DIV];
  // word length field sets the last data bit
  assign wlast = {1'b1, lfmt[1:0]} - 3'd1 + 3'd1;
  assign tick = (div_cnt == 16'h0000);
  assign tx_load = thr_full && (tx_state == ST_IDLE) && tick;
  assign tx_holding_empty = ~thr_full;
  // xt mode looks only at the shift register
  assign tx_all_empty = xt_mode_i ? (tx_state == ST_IDLE)
                          : (tx_holding_empty && tx_state == ST_IDLE);
  // loop mode feeds our own line back in
  assign rx_in = mctl[MC_LOOP] ? txd_o : rxd_i;
  assign mnow = {dcd_i, ri_i, dsr_i, cts_i};
  assign wr_any = req_i.wr;
  assign rd_any = req_i.rd;
  assign lst_v = {1'b0, tx_all_empty, tx_holding_empty, bi, fe, pe, oe, dr};

  // ident code, highest priority first
  always_comb begin
    if (ien[2] && (oe || pe || fe || bi)) begin
      iid_v = IID_LINE;
    end else if (ien[0] && dr) begin
      iid_v = IID_RX;
    end else if (ien[1] && tx_holding_empty_irq) begin
      iid_v = IID_TX;
    end else if (ien[3] && (|mdelta)) begin
      iid_v = IID_MODEM;
    end else begin
      iid_v = IID_NONE;
    end
  end

  // read value selection
  always_comb begin
    case (req_i.addr)
      // newest char on read of offset 0
      OFS_DATA: rd_v = dsel ? divisor[7:0] : rx_data;
      // upper four enable bits read zero
      OFS_IEN: rd_v = dsel ? divisor[15:8] : {4'h0, ien[3:0]};
      // fifo bits 3, 6, 7 of ident stay zero
      OFS_IID: rd_v = iid_v;
      OFS_LFMT: rd_v = lfmt;
      OFS_MCTL: rd_v = {3'b000, mctl[4:0]};
      OFS_LST: rd_v = lst_v;
      OFS_MST: rd_v = {mnow, mdelta};
      // spare byte hidden in xt mode
      OFS_SPARE: rd_v = xt_mode_i ? BYTE_ZERO : spare;
      OFS_EVT_STAT: rd_v = {4'h0, evt_stat};
      OFS_EVT_EN: rd_v = {4'h0, evt_en};
      default: rd_v = BYTE_ZERO;
    endcase
  end

  // read data stands for one cycle after the strobe only
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= BYTE_ZERO;
    end else begin
      rdata_o <= rd_any ? rd_v : BYTE_ZERO;
    end
  end

  // software-written control registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ien <= BYTE_ZERO;
      lfmt <= BYTE_ZERO;
      mctl <= BYTE_ZERO;
      spare <= BYTE_ZERO;
      divisor <= DIV_RESET;
      evt_en <= 4'h0;
    end else if (wr_any) begin
      case (req_i.addr)
        // divisor bytes share offsets 0 and 1
        OFS_DATA: if (dsel) divisor[7:0] <= req_i.wdata;
        OFS_IEN: begin
          if (dsel) begin
            divisor[15:8] <= req_i.wdata;
          end else begin
            ien <= {4'h0, req_i.wdata[3:0]};
          end
        end
        // whole format byte stored as written
        OFS_LFMT: lfmt <= req_i.wdata;
        // aux bits 2,3 kept, reach no pin
        OFS_MCTL: mctl <= {3'b000, req_i.wdata[4:0]};
        OFS_SPARE: if (!xt_mode_i) spare <= req_i.wdata;
        OFS_EVT_EN: evt_en <= req_i.wdata[3:0];
        // fifo control, dma select included, has no effect
        default: evt_en <= evt_en;
      endcase
    end
  end

  // modem outputs straight from control flops
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dtr_o <= 1'b0;
      rts_o <= 1'b0;
    end else begin
      dtr_o <= (wr_any && req_i.addr == OFS_MCTL) ? req_i.wdata[0]
                                                  : mctl[0];
      rts_o <= (wr_any && req_i.addr == OFS_MCTL) ? req_i.wdata[1]
                                                  : mctl[1];
    end
  end

  // baud tick: divisor of zero behaves as one
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt <= DIV_RESET;
    end else if (tick) begin
      div_cnt <= (divisor == DIV_RESET) ? DIV_RESET : divisor - 16'h0001;
    end else begin
      div_cnt <= div_cnt - 16'h0001;
    end
  end

  // holding register; a new write wins over the move to the shifter
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // empty holding gives line state 0x60
      thr_data <= BYTE_ZERO;
      thr_full <= 1'b0;
    end else if (wr_any && req_i.addr == OFS_DATA && !dsel) begin
      // write loads tx, rx data untouched
      thr_data <= req_i.wdata;
      thr_full <= 1'b1;
    end else if (tx_load) begin
      thr_full <= 1'b0;
    end
  end

  // transmit shifter, one bit per sixteen ticks
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_state <= ST_IDLE;
      tx_sub <= 4'h0;
      tx_idx <= 3'd0;
      tx_sr <= BYTE_ZERO;
      tx_stop2 <= 1'b0;
      txd_o <= 1'b1;
    end else begin
      if (tx_load) begin
        tx_state <= ST_START;
        tx_sub <= 4'h0;
        tx_sr <= thr_data & (8'hFF >> (3'd7 - wlast));
        txd_o <= ~lfmt[LF_BREAK] & 1'b0;
      end else if (tick && tx_state != ST_IDLE) begin
        tx_sub <= tx_sub + 4'h1;
        if (tx_sub == SUB_LAST) begin
          case (tx_state)
            ST_START: begin
              tx_state <= ST_DATA;
              tx_idx <= 3'd0;
              txd_o <= ~lfmt[LF_BREAK] & tx_sr[0];
            end
            ST_DATA: begin
              if (tx_idx == wlast) begin
                tx_state <= lfmt[LF_PAR] ? ST_PAR : ST_STOP;
                tx_stop2 <= lfmt[LF_STOP];
                // stick, even or odd parity bit
                txd_o <= ~lfmt[LF_BREAK] & (lfmt[LF_PAR] ?
                  (lfmt[LF_STICK] ? ~lfmt[LF_EVEN]
                   : (lfmt[LF_EVEN] ? ^tx_sr : ~^tx_sr)) : 1'b1);
              end else begin
                tx_idx <= tx_idx + 3'd1;
                txd_o <= ~lfmt[LF_BREAK] & tx_sr[tx_idx + 3'd1];
              end
            end
            ST_PAR: begin
              tx_state <= ST_STOP;
              txd_o <= ~lfmt[LF_BREAK];
            end
            ST_STOP: begin
              tx_stop2 <= 1'b0;
              if (!tx_stop2) tx_state <= ST_IDLE;
              txd_o <= ~lfmt[LF_BREAK];
            end
            default: tx_state <= ST_IDLE;
          endcase
        end
      end else if (tx_state == ST_IDLE) begin
        // break holds the line low while idle too
        txd_o <= ~lfmt[LF_BREAK];
      end
    end
  end

  // receive sampler, mid-bit sampling after start check
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_state <= ST_IDLE;
      rx_sub <= 4'h0;
      rx_idx <= 3'd0;
      rx_sr <= BYTE_ZERO;
      rx_pbit <= 1'b0;
      rx_data <= BYTE_ZERO;
      rx_done <= 1'b0;
      rx_pe <= 1'b0;
      rx_fe <= 1'b0;
      rx_bi <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (tick) begin
        rx_sub <= rx_sub + 4'h1;
        case (rx_state)
          ST_IDLE: begin
            rx_sub <= 4'h0;
            if (!rx_in) rx_state <= ST_START;
          end
          ST_START: begin
            if (rx_sub == SUB_MID) begin
              rx_sub <= 4'h0;
              rx_idx <= 3'd0;
              rx_sr <= BYTE_ZERO;
              rx_state <= rx_in ? ST_IDLE : ST_DATA;
            end
          end
          ST_DATA: begin
            if (rx_sub == SUB_LAST) begin
              // first sample lands in bit 0
              rx_sr[rx_idx] <= rx_in;
              rx_idx <= rx_idx + 3'd1;
              if (rx_idx == wlast) begin
                rx_state <= lfmt[LF_PAR] ? ST_PAR : ST_STOP;
              end
            end
          end
          ST_PAR: begin
            if (rx_sub == SUB_LAST) begin
              rx_pbit <= rx_in;
              rx_state <= ST_STOP;
            end
          end
          ST_STOP: begin
            if (rx_sub == SUB_LAST) begin
              rx_state <= ST_IDLE;
              rx_data <= rx_sr;
              rx_done <= 1'b1;
              rx_fe <= ~rx_in;
              rx_bi <= ~rx_in && (rx_sr == BYTE_ZERO) && !rx_pbit;
              rx_pe <= lfmt[LF_PAR] && (rx_pbit != (lfmt[LF_STICK] ?
                ~lfmt[LF_EVEN] : (lfmt[LF_EVEN] ? ^rx_sr : ~^rx_sr)));
            end
          end
          default: rx_state <= ST_IDLE;
        endcase
      end
    end
  end

  // line state flags: reads clear, fresh events win
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dr <= 1'b0;
      oe <= 1'b0;
      pe <= 1'b0;
      fe <= 1'b0;
      bi <= 1'b0;
    end else begin
      if (rd_any && req_i.addr == OFS_DATA && !dsel) dr <= 1'b0;
      if (rd_any && req_i.addr == OFS_LST) begin
        oe <= 1'b0;
        pe <= 1'b0;
        fe <= 1'b0;
        bi <= 1'b0;
      end
      if (rx_done) begin
        dr <= 1'b1;
        // overrun: previous char never read
        if (dr && !(rd_any && req_i.addr == OFS_DATA && !dsel)) oe <= 1'b1;
        if (rx_pe) pe <= 1'b1;
        if (rx_fe) fe <= 1'b1;
        if (rx_bi) bi <= 1'b1;
      end
    end
  end

  // tx empty irq latch: armed on emptying, dropped by ident read or data write
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_holding_empty_irq <= 1'b0;
    end else if (tx_load ||
                 (wr_any && req_i.addr == OFS_IEN && !dsel &&
                  req_i.wdata[1] && !ien[1] && tx_holding_empty)) begin
      tx_holding_empty_irq <= 1'b1;
    end else if ((wr_any && req_i.addr == OFS_DATA && !dsel) ||
                 (rd_any && req_i.addr == OFS_IID && iid_v == IID_TX)) begin
      tx_holding_empty_irq <= 1'b0;
    end
  end

  // modem deltas, ring counts on its trailing edge only
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mprev <= 4'h0;
      mdelta <= 4'h0;
    end else begin
      mprev <= mnow;
      mdelta <= ((rd_any && req_i.addr == OFS_MST) ? 4'h0 : mdelta) |
                {mprev[3] ^ mnow[3], mprev[2] & ~mnow[2],
                 mprev[1:0] ^ mnow[1:0]};
    end
  end

  // sticky event status, write-one clear; a set in the same cycle wins
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      evt_stat <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      evt_stat <= (evt_stat &
                   ~((wr_any && req_i.addr == OFS_EVT_CLR) ?
                     req_i.wdata[3:0] : 4'h0)) |
                  {|mdelta, rx_done && (rx_pe || rx_fe || rx_bi),
                   tx_load, rx_done};
      irq_o <= |(evt_stat & evt_en);
    end
  end

  // checks
  logic first_cyc; // high in the first cycle after reset release
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      first_cyc <= 1'b1;
    end else begin
      first_cyc <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_rd(logic [3:0] a);
    req_i.rd && req_i.addr == a;
  endsequence
  sequence s_wr(logic [3:0] a);
    req_i.wr && req_i.addr == a;
  endsequence

  property p_div_read;
    s_rd(OFS_DATA) ##0 dsel |=> rdata_o == $past(divisor[7:0]);
  endproperty
  a_div_read: assert property (p_div_read)
    else $error("divisor low byte not returned");
  property p_rx_read;
    s_rd(OFS_DATA) ##0 !dsel |=> rdata_o == $past(rx_data);
  endproperty
  a_rx_read: assert property (p_rx_read)
    else $error("received char not returned");
  property p_wr_keeps_rx;
    s_wr(OFS_DATA) ##0 !dsel ##0
      !(tick && rx_state == ST_STOP && rx_sub == SUB_LAST)
      |=> $stable(rx_data) && thr_full;
  endproperty
  a_wr_keeps_rx: assert property (p_wr_keeps_rx)
    else $error("tx write disturbed rx data");
  property p_lsb_first;
    tx_state == ST_START && tick && tx_sub == SUB_LAST &&
      !lfmt[LF_BREAK] |=> txd_o == tx_sr[0];
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("first data bit is not bit 0");
  property p_ien_upper;
    s_rd(OFS_IEN) ##0 !dsel |=> rdata_o[7:4] == 4'h0;
  endproperty
  a_ien_upper: assert property (p_ien_upper)
    else $error("enable upper bits not zero");
  property p_fifo_bits;
    s_rd(OFS_IID) |=> rdata_o[7:6] == 2'b00 && !rdata_o[3];
  endproperty
  a_fifo_bits: assert property (p_fifo_bits)
    else $error("fifo ident bits not zero");
  property p_aux_kept;
    s_wr(OFS_MCTL) |=> mctl[3:2] == $past(req_i.wdata[3:2]);
  endproperty
  a_aux_kept: assert property (p_aux_kept)
    else $error("aux bits not stored");
  property p_xt_empty;
    xt_mode_i && tx_state == ST_IDLE |-> lst_v[6];
  endproperty
  a_xt_empty: assert property (p_xt_empty)
    else $error("tx empty not set in xt mode");
  property p_xt_spare;
    s_rd(OFS_SPARE) ##0 xt_mode_i |=> rdata_o == BYTE_ZERO;
  endproperty
  a_xt_spare: assert property (p_xt_spare)
    else $error("spare byte visible in xt mode");
  property p_lst_reset;
    first_cyc |-> lst_v == LST_RESET;
  endproperty
  a_lst_reset: assert property (p_lst_reset)
    else $error("line state reset value wrong");
  property p_line_first;
    ien[2] && ien[0] && dr && (oe || pe || fe || bi) ##0 s_rd(OFS_IID)
      |=> rdata_o == IID_LINE;
  endproperty
  a_line_first: assert property (p_line_first)
    else $error("line status irq not preferred");
endmodule : ursm_channel

// ==== tb/ursm_remote.sv ====
// behavioural model of the remote serial device on the far side of the line
`timescale 1ns/10ps
module ursm_remote #(
  parameter int BIT_CLKS = 16 // clocks per bit with a divisor of one
) (
  // clock shared with the channel for timing only
  input wire logic clk_i,
  // serial lines seen from the remote side
  input wire logic txd_i,
  output logic rxd_o
);
  // line idles high, like a real marking line
  initial rxd_o = 1'b1;

  // send one 8-bit frame; stop low makes a framing fault on purpose
  task automatic send(input logic [7:0] data, input logic stop);
    int i;
    for (i = -1; i < 9; i++) begin
      rxd_o <= (i < 0) ? 1'b0 : ((i < 8) ? data[i] : stop);
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask : send

  // capture one 8-bit frame; sampled on the falling edge, clear of updates
  task automatic recv(output logic [7:0] data, output logic ok);
    int n;
    int i;
    ok = 1'b0;
    data = 8'h00;
    n = 0;
    while (txd_i !== 1'b0 && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
    if (n < 4000) begin
      repeat (BIT_CLKS / 2) @(negedge clk_i);
      ok = (txd_i === 1'b0);
      for (i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(negedge clk_i);
        data[i] = txd_i;
      end
      repeat (BIT_CLKS) @(negedge clk_i);
      ok = ok && (txd_i === 1'b1);
    end
  endtask : recv
endmodule : ursm_remote

// ==== tb/ursm_channel_tb_top.sv ====
// self-checking bench for the serial channel register set
`timescale 1ns/10ps
module ursm_channel_tb_top;
  import ursm_pkg::*;
  logic clk_i = 1'b0; // 50 MHz clock
  logic arst_n_i = 1'b0; // reset held at start
  ursm_bus_req_s req_i = '0; // host port request
  logic [7:0] rdata_o;
  logic xt_mode_i = 1'b0;
  logic rxd_i;
  logic txd_o;
  logic cts_i = 1'b0; // only cts is toggled; the rest stay idle
  logic dtr_o;
  logic rts_o;
  logic irq_o;
  int bad_count = 0;
  int check_count = 0;

  always #10 clk_i = ~clk_i;

  ursm_channel dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req_i),
    .rdata_o(rdata_o), .xt_mode_i(xt_mode_i), .rxd_i(rxd_i),
    .txd_o(txd_o), .cts_i(cts_i), .dsr_i(1'b0), .ri_i(1'b0),
    .dcd_i(1'b0), .dtr_o(dtr_o), .rts_o(rts_o), .irq_o(irq_o));
  ursm_remote remote (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));

  // verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  // compare one value, four-state exact
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string msg);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, seen,
               exp);
    end
  endtask : check

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req_i.wr <= 1'b0;
  endtask : wr

  // one-cycle read strobe; data stands only in the following cycle
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp,
                        input string msg);
    @(posedge clk_i);
    req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req_i.rd <= 1'b0;
    #1 check(rdata_o, exp, msg);
  endtask : rd_chk

  // reset with the mode strap settled while reset is low
  task automatic do_reset(input logic xt);
    arst_n_i <= 1'b0;
    xt_mode_i <= xt;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
  endtask : do_reset

  // bounded poll of one register until a mask bit is set
  task automatic wait_reg(input logic [3:0] a, input logic [7:0] m);
    int n;
    logic [7:0] v;
    v = 8'h00;
    for (n = 0; n < 400 && (v & m) == 8'h00; n++) begin
      @(posedge clk_i);
      req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      req_i.rd <= 1'b0;
      #1 v = rdata_o;
    end
    if ((v & m) == 8'h00) check(v, m, "register poll timed out");
  endtask : wait_reg

  // reset values, fifo bits, dma select, divisor and enable mask
  task automatic t_regs;
    rd_chk(OFS_LST, 8'h60, "line state reset");
    rd_chk(OFS_IID, 8'h01, "ident reset");
    wr(OFS_IID, 8'hC9);
    rd_chk(OFS_IID, 8'h01, "ident after fifo ctrl");
    rd_chk(OFS_LST, 8'h60, "line state after dma bit");
    wr(OFS_LFMT, 8'h83);
    wr(OFS_DATA, 8'hA5);
    wr(OFS_IEN, 8'h5A);
    rd_chk(OFS_DATA, 8'hA5, "divisor low");
    rd_chk(OFS_IEN, 8'h5A, "divisor high");
    wr(OFS_DATA, 8'h01);
    wr(OFS_IEN, 8'h00);
    wr(OFS_LFMT, 8'h03);
    rd_chk(OFS_LFMT, 8'h03, "line format");
    wr(OFS_IEN, 8'hFF);
    rd_chk(OFS_IEN, 8'h0F, "enable mask upper bits");
    rd_chk(OFS_IID, 8'h02, "tx empty ident");
    wr(OFS_IEN, 8'h00);
    rd_chk(OFS_LST, 8'h60, "data read did not touch rx");
    rd_chk(4'hB, 8'h00, "unmapped offset");
  endtask : t_regs

  // break, transmit order and spare byte in normal mode
  task automatic t_tx;
    logic [7:0] d;
    logic ok;
    wr(OFS_LFMT, 8'h43);
    // the line follows the stored format one cycle after the write
    @(posedge clk_i);
    #1 check({7'd0, txd_o}, 8'h00, "break drives line low");
    wr(OFS_LFMT, 8'h03);
    @(posedge clk_i);
    #1 check({7'd0, txd_o}, 8'h01, "break released");
    fork
      remote.recv(d, ok);
      wr(OFS_DATA, 8'hB4);
    join
    check(d, 8'hB4, "tx char lsb first");
    check({7'd0, ok}, 8'h01, "tx framing");
    wr(OFS_SPARE, 8'h5A);
    rd_chk(OFS_SPARE, 8'h5A, "spare byte normal");
  endtask : t_tx

  // receive with events, interrupt raise, mask and clear
  task automatic t_rx;
    wr(OFS_EVT_CLR, 8'h0F);
    wr(OFS_EVT_EN, 8'h01);
    remote.send(8'h96, 1'b1);
    wait_reg(OFS_LST, 8'h01);
    check({7'd0, irq_o}, 8'h01, "irq on rx event");
    rd_chk(OFS_EVT_STAT, 8'h01, "event status");
    wr(OFS_EVT_EN, 8'h00);
    repeat (2) @(posedge clk_i);
    #1 check({7'd0, irq_o}, 8'h00, "irq masked");
    wr(OFS_EVT_EN, 8'h01);
    wr(OFS_EVT_CLR, 8'h01);
    repeat (2) @(posedge clk_i);
    #1 check({7'd0, irq_o}, 8'h00, "irq cleared");
    rd_chk(OFS_DATA, 8'h96, "rx char");
    rd_chk(OFS_LST, 8'h60, "data ready cleared");
  endtask : t_rx

  // line error against rx data priority
  task automatic t_prio;
    wr(OFS_IEN, 8'h05);
    remote.send(8'h3C, 1'b0);
    repeat (40) @(posedge clk_i);
    // poll ident, not line state: a line state read clears the error
    wait_reg(OFS_IID, 8'h04);
    rd_chk(OFS_IID, 8'h06, "line error first");
    rd_chk(OFS_LST, 8'h69, "framing fault flagged");
    rd_chk(OFS_IID, 8'h04, "rx data next");
    rd_chk(OFS_DATA, 8'h3C, "errored char");
    rd_chk(OFS_IID, 8'h01, "nothing pending");
    wr(OFS_IEN, 8'h00);
  endtask : t_prio

  // aux outputs and modem lines
  task automatic t_modem;
    wr(OFS_MCTL, 8'h0C);
    rd_chk(OFS_MCTL, 8'h0C, "aux bits stored");
    check({6'd0, dtr_o, rts_o}, 8'h00, "aux drive no pin");
    wr(OFS_MCTL, 8'h03);
    #1 check({6'd0, dtr_o, rts_o}, 8'h03, "dtr rts");
    @(posedge clk_i);
    cts_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd_chk(OFS_MST, 8'h11, "cts delta");
    rd_chk(OFS_MST, 8'h10, "delta cleared");
  endtask : t_modem

  // xt mode: spare byte gone, tx empty follows shifter
  task automatic t_xt;
    logic [7:0] d;
    logic ok;
    do_reset(1'b1);
    wr(OFS_SPARE, 8'h5A);
    rd_chk(OFS_SPARE, 8'h00, "spare unavailable");
    wr(OFS_LFMT, 8'h03);
    fork
      remote.recv(d, ok);
      wr(OFS_DATA, 8'h81);
    join
    check(d, 8'h81, "xt tx char");
    wait_reg(OFS_LST, 8'h40);
    rd_chk(OFS_LST, 8'h60, "tx empty after shift");
  endtask : t_xt

  // hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    wrap_up();
  end

  // main sequence
  initial begin
    do_reset(1'b0);
    t_regs();
    t_tx();
    t_rx();
    t_prio();
    t_modem();
    t_xt();
    wrap_up();
  end
endmodule : ursm_channel_tb_top
